// >>> pps_seq_regs.svh
`ifndef PPS_SEQ_REGS_SVH
`define PPS_SEQ_REGS_SVH

// Widths of the output pattern, the program address and the instruction word.
`define SEQ_OUT_BITS        12
`define SEQ_ADDR_BITS       12
`define SEQ_MEM_DEPTH       4096
`define SEQ_WORD_BITS       71
`define SEQ_DELAY_BITS      32
`define SEQ_DATA_BITS       20
`define SEQ_LONG_BITS       52
`define SEQ_SHORT_BITS      3
`define SEQ_STACK_DEPTH     8
`define SEQ_STATUS_BITS     5

// Low bit of each instruction field.
`define SEQ_F_DELAY_LO      0
`define SEQ_F_DATA_LO       32
`define SEQ_F_OP_LO         52
`define SEQ_F_SHORT_LO      56
`define SEQ_F_PAT_LO        59

// Timing: core clock period and the shortest instruction in core cycles.
`define SEQ_CLK_PERIOD_NS   100
`define SEQ_MIN_INSTR_CYC   6
// Cycles of an instruction spent outside the countdown (load and fetch plus one).
`define SEQ_PIPE_CYC        3

// Status bit positions.
`define SEQ_ST_RUN          0
`define SEQ_ST_STOP         1
`define SEQ_ST_WAIT         2
`define SEQ_ST_IDLE         3
`define SEQ_ST_ERR          4

`endif

// >>> pps_seq_pkg.sv
`default_nettype none
package pps_seq_pkg;

   // Sequencer control states.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_FETCH = 3'h1,
      ST_LOAD  = 3'h2,
      ST_EXEC  = 3'h3,
      ST_WAIT  = 3'h4,
      ST_HALT  = 3'h5
   } seq_state_t;

   // Flow-control opcodes; unlisted codes behave as continue.
   typedef enum logic [3:0] {
      OP_CONTINUE   = 4'h0,
      OP_STOP       = 4'h1,
      OP_LOOP       = 4'h2,
      OP_END_LOOP   = 4'h3,
      OP_CALL       = 4'h4,
      OP_RETURN     = 4'h5,
      OP_BRANCH     = 4'h6,
      OP_LONG_DELAY = 4'h7,
      OP_WAIT       = 4'h8
   } seq_op_t;

endpackage
`default_nettype wire

// >>> pps_program_mem.sv
`include "pps_seq_regs.svh"
`default_nettype none
module pps_program_mem (
   input  wire logic                          core_clk,
   input  wire logic                          wrEn,
   input  wire logic [`SEQ_ADDR_BITS-1:0]     wrAddr,
   input  wire logic [`SEQ_WORD_BITS-1:0]     wrData,
   input  wire logic [`SEQ_ADDR_BITS-1:0]     rdAddr,
   output logic      [`SEQ_WORD_BITS-1:0]     rdData
);

   logic [`SEQ_WORD_BITS-1:0] memArray_q [`SEQ_MEM_DEPTH];
   logic [`SEQ_WORD_BITS-1:0] rdData_q;

   // Host writes and sequencer reads use separate ports, so loading never stalls a read.
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         memArray_q[wrAddr] <= wrData;
      end
      rdData_q <= memArray_q[rdAddr];
   end

   assign rdData = rdData_q;

endmodule
`default_nettype wire

// >>> pulse_pattern_sequencer.sv
// Function
// [R01] Twelve output bits are each set by the pattern field of the executing instruction.
// [R02] Each instruction holds its pattern for its own programmed duration.
// [R03] No instruction lasts less than six core clock periods.
// [R04] A pulse as short as one core clock period can be produced.
// [R05] The program memory holds 4096 instruction words loaded by the host.
// [R06] A normal instruction carries a delay count of up to two to the thirty-second cycles.
// [R07] A double-length instruction extends the delay to up to two to the fifty-second cycles.
// [R08] Delays resolve to one core clock period whatever their length.
// [R09] Branches, calls and loops are supported with eight-level call and loop stacks.
// [R10] Each loop has a 20-bit repetition counter.
// [R11] Dedicated external trigger and reset lines start and reset execution.
// [R12] The outside party re-triggers no faster than 15 MHz.
// [R13] Execution status is driven on output lines and is readable by the host.
// [R14] The sequencer runs on the core clock multiplied from the on-board reference.
// [R15] The host loads memory and controls the sequencer through the host bus controller.
// [R16] All output bits change together on the clock at instruction boundaries and hold between; a short pulse clears them to zero inside an instruction.
`include "pps_seq_regs.svh"
`default_nettype none
module pulse_pattern_sequencer (
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic                          extTrigger,
   input  wire logic                          extReset,
   input  wire logic                          hostStart,
   input  wire logic                          hostReset,
   input  wire logic                          progWrite,
   input  wire logic [`SEQ_ADDR_BITS-1:0]     progAddr,
   input  wire logic [`SEQ_WORD_BITS-1:0]     progWord,
   output logic      [`SEQ_OUT_BITS-1:0]      patternOut,
   output logic      [`SEQ_STATUS_BITS-1:0]   statusLines,
   output logic      [`SEQ_STATUS_BITS-1:0]   hostStatus
);

   localparam int MIN_CYC = `SEQ_MIN_INSTR_CYC;

   pps_seq_pkg::seq_state_t state_q, state_d;
   logic [2:0]                       trigSync_q;
   logic [1:0]                       rstSync_q;
   logic [`SEQ_ADDR_BITS-1:0]        pc_q;
   logic [`SEQ_LONG_BITS-1:0]        execCnt_q;
   logic [`SEQ_SHORT_BITS-1:0]       shortCnt_q;
   logic [`SEQ_OUT_BITS-1:0]         out_q;
   logic [`SEQ_STATUS_BITS-1:0]      status_q;
   logic                             haltAfter_q;
   logic                             waitAfter_q;
   logic                             err_q;
   logic [3:0]                       callSp_q;
   logic [3:0]                       loopSp_q;
   logic [`SEQ_ADDR_BITS-1:0]        callStack_q [`SEQ_STACK_DEPTH];
   logic [`SEQ_DATA_BITS-1:0]        loopStack_q [`SEQ_STACK_DEPTH];
   logic [`SEQ_WORD_BITS-1:0]        memWord;

   // Host writes go straight into program memory; the read port follows the program counter.
   pps_program_mem u_mem (
      .core_clk (core_clk),
      .wrEn     (progWrite),
      .wrAddr   (progAddr),
      .wrData   (progWord),
      .rdAddr   (pc_q),
      .rdData   (memWord)
   ); // [R05] [R15]

   // Pin inputs pass two flip-flops; the third stage only feeds the edge detector.
   wire trigEdge  = trigSync_q[1] & ~trigSync_q[2];
   wire resetAct  = rstSync_q[1] | hostReset; // [R11]
   wire startAct  = trigEdge | hostStart; // [R11]

   // Instruction field decode.
   wire [`SEQ_OUT_BITS-1:0]   patF   = memWord[`SEQ_F_PAT_LO +: `SEQ_OUT_BITS];
   wire [`SEQ_SHORT_BITS-1:0] shortF = memWord[`SEQ_F_SHORT_LO +: `SEQ_SHORT_BITS];
   wire [`SEQ_DATA_BITS-1:0]  dataF  = memWord[`SEQ_F_DATA_LO +: `SEQ_DATA_BITS];
   wire [`SEQ_DELAY_BITS-1:0] delayF = memWord[`SEQ_F_DELAY_LO +: `SEQ_DELAY_BITS];
   wire pps_seq_pkg::seq_op_t opF    = pps_seq_pkg::seq_op_t'(memWord[`SEQ_F_OP_LO +: 4]);
   wire isLoad = (state_q == pps_seq_pkg::ST_LOAD);

   // Double-length instructions take the data field as the upper delay bits.
   wire [`SEQ_LONG_BITS-1:0] rawDelay = (opF == pps_seq_pkg::OP_LONG_DELAY) ?
                                        {dataF, delayF} : {{`SEQ_DATA_BITS{1'b0}}, delayF}; // [R06] [R07]
   // Too-short delays are stretched to the shortest instruction rather than refused.
   wire [`SEQ_LONG_BITS-1:0] effDelay = (rawDelay < `SEQ_LONG_BITS'(MIN_CYC)) ?
                                        `SEQ_LONG_BITS'(MIN_CYC) : rawDelay; // [R03]

   // Flow decode: stack tops, stack faults and the next address.
   wire [2:0] callTop = 3'(callSp_q - 4'h1);
   wire [2:0] loopTop = 3'(loopSp_q - 4'h1);
   wire [`SEQ_ADDR_BITS-1:0] pcInc = pc_q + `SEQ_ADDR_BITS'(1);
   wire loopDone  = (loopStack_q[loopTop] == `SEQ_DATA_BITS'(0));
   wire stackErr  = ((opF == pps_seq_pkg::OP_LOOP)     && (loopSp_q == 4'h8)) ||
                    ((opF == pps_seq_pkg::OP_END_LOOP) && (loopSp_q == 4'h0)) ||
                    ((opF == pps_seq_pkg::OP_CALL)     && (callSp_q == 4'h8)) ||
                    ((opF == pps_seq_pkg::OP_RETURN)   && (callSp_q == 4'h0)); // [R09]
   wire doPushCall = isLoad && !stackErr && (opF == pps_seq_pkg::OP_CALL);
   wire doPopCall  = isLoad && !stackErr && (opF == pps_seq_pkg::OP_RETURN);
   wire doPushLoop = isLoad && !stackErr && (opF == pps_seq_pkg::OP_LOOP);
   wire doEndLoop  = isLoad && !stackErr && (opF == pps_seq_pkg::OP_END_LOOP);
   wire [`SEQ_ADDR_BITS-1:0] nextPc =
      (opF == pps_seq_pkg::OP_BRANCH || opF == pps_seq_pkg::OP_CALL) ? dataF[`SEQ_ADDR_BITS-1:0] :
      (opF == pps_seq_pkg::OP_RETURN) ? callStack_q[callTop] :
      (opF == pps_seq_pkg::OP_END_LOOP && !loopDone) ? dataF[`SEQ_ADDR_BITS-1:0] : pcInc; // [R09] [R10]

   // Next state; reset from a pin or the host overrides everything.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         pps_seq_pkg::ST_IDLE:  if (startAct) state_d = pps_seq_pkg::ST_FETCH; // [R11]
         pps_seq_pkg::ST_FETCH: state_d = pps_seq_pkg::ST_LOAD;
         pps_seq_pkg::ST_LOAD:  state_d = pps_seq_pkg::ST_EXEC;
         pps_seq_pkg::ST_EXEC: begin
            if (execCnt_q == `SEQ_LONG_BITS'(0)) begin
               state_d = haltAfter_q ? pps_seq_pkg::ST_HALT :
                         waitAfter_q ? pps_seq_pkg::ST_WAIT : pps_seq_pkg::ST_FETCH;
            end
         end
         pps_seq_pkg::ST_WAIT:  if (startAct) state_d = pps_seq_pkg::ST_FETCH;
         pps_seq_pkg::ST_HALT:  if (startAct) state_d = pps_seq_pkg::ST_FETCH;
         default:               state_d = pps_seq_pkg::ST_IDLE;
      endcase
      if (resetAct) begin
         state_d = pps_seq_pkg::ST_IDLE;
      end
   end

   // Pin synchronisers; the sequencer runs entirely on the multiplied core clock.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         trigSync_q <= 3'h0;
         rstSync_q  <= 2'h0;
      end else begin
         trigSync_q <= {trigSync_q[1:0], extTrigger};
         rstSync_q  <= {rstSync_q[0], extReset}; // [R14]
      end
   end

   // Program counter, countdown and the registered pattern.
   always_ff @(posedge core_clk) begin
      if (!rst_n || resetAct) begin
         state_q     <= pps_seq_pkg::ST_IDLE;
         pc_q        <= `SEQ_ADDR_BITS'(0);
         execCnt_q   <= `SEQ_LONG_BITS'(0);
         shortCnt_q  <= `SEQ_SHORT_BITS'(0);
         out_q       <= `SEQ_OUT_BITS'(0);
         haltAfter_q <= 1'b0;
         waitAfter_q <= 1'b0;
         err_q       <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == pps_seq_pkg::ST_HALT && startAct) begin
            pc_q  <= `SEQ_ADDR_BITS'(0);
            err_q <= 1'b0;
         end else if (isLoad) begin
            // The whole pattern loads in one edge so every bit moves together.
            out_q       <= patF; // [R01] [R16]
            shortCnt_q  <= shortF; // [R04]
            execCnt_q   <= effDelay - `SEQ_LONG_BITS'(`SEQ_PIPE_CYC); // [R02] [R08]
            pc_q        <= nextPc;
            haltAfter_q <= (opF == pps_seq_pkg::OP_STOP) || stackErr;
            waitAfter_q <= (opF == pps_seq_pkg::OP_WAIT);
            err_q       <= stackErr;
         end else if (state_q == pps_seq_pkg::ST_EXEC) begin
            execCnt_q <= execCnt_q - `SEQ_LONG_BITS'(1); // [R08]
            if (shortCnt_q != `SEQ_SHORT_BITS'(0)) begin
               shortCnt_q <= shortCnt_q - `SEQ_SHORT_BITS'(1);
            end
            if (shortCnt_q == `SEQ_SHORT_BITS'(1)) begin
               out_q <= `SEQ_OUT_BITS'(0); // [R04]
            end
         end
      end
   end

   // Call and loop stacks; a fault halts the program instead of corrupting a stack.
   always_ff @(posedge core_clk) begin
      if (!rst_n || resetAct || (state_q == pps_seq_pkg::ST_HALT && startAct)) begin
         callSp_q <= 4'h0;
         loopSp_q <= 4'h0;
      end else begin
         if (doPushCall) begin
            callStack_q[callSp_q[2:0]] <= pcInc;
            callSp_q <= callSp_q + 4'h1; // [R09]
         end else if (doPopCall) begin
            callSp_q <= callSp_q - 4'h1;
         end
         if (doPushLoop) begin
            loopStack_q[loopSp_q[2:0]] <= dataF;
            loopSp_q <= loopSp_q + 4'h1; // [R09]
         end else if (doEndLoop) begin
            if (loopDone) begin
               loopSp_q <= loopSp_q - 4'h1;
            end else begin
               loopStack_q[loopTop] <= loopStack_q[loopTop] - `SEQ_DATA_BITS'(1); // [R10]
            end
         end
      end
   end

   // One status register feeds both the status pins and the host readback.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_q <= `SEQ_STATUS_BITS'(0);
      end else begin
         status_q[`SEQ_ST_RUN]  <= (state_q == pps_seq_pkg::ST_FETCH) || isLoad ||
                                   (state_q == pps_seq_pkg::ST_EXEC);
         status_q[`SEQ_ST_STOP] <= (state_q == pps_seq_pkg::ST_HALT);
         status_q[`SEQ_ST_WAIT] <= (state_q == pps_seq_pkg::ST_WAIT);
         status_q[`SEQ_ST_IDLE] <= (state_q == pps_seq_pkg::ST_IDLE);
         status_q[`SEQ_ST_ERR]  <= err_q; // [R13]
      end
   end

   assign patternOut  = out_q;
   assign statusLines = status_q;
   assign hostStatus  = status_q;

   // Checking helpers: cycles since the last load and the duration that load promised.
   logic [`SEQ_LONG_BITS:0]   gap_q;
   logic [`SEQ_LONG_BITS-1:0] expDelay_q;
   logic                      chainOk_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n || resetAct) begin
         gap_q      <= '0;
         expDelay_q <= '0;
         chainOk_q  <= 1'b0;
      end else if (isLoad) begin
         gap_q      <= (`SEQ_LONG_BITS+1)'(1);
         expDelay_q <= effDelay;
         chainOk_q  <= 1'b1;
      end else begin
         gap_q <= gap_q + (`SEQ_LONG_BITS+1)'(1);
         if (state_q == pps_seq_pkg::ST_WAIT || state_q == pps_seq_pkg::ST_HALT) begin
            chainOk_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_fetchLoad;
      (state_q == pps_seq_pkg::ST_FETCH) ##1 (state_q == pps_seq_pkg::ST_LOAD);
   endsequence

   sequence s_shortLoad;
      isLoad && (shortF == 3'h1) && !resetAct;
   endsequence

   chk_trigger_start: assert property ( // [R11]
      (state_q == pps_seq_pkg::ST_IDLE || state_q == pps_seq_pkg::ST_WAIT) && trigEdge && !resetAct
      |=> s_fetchLoad)
      else $error("trigger did not start the program");
   chk_reset_line: assert property ( // [R11]
      resetAct |=> (state_q == pps_seq_pkg::ST_IDLE) && (patternOut == 12'h000))
      else $error("reset did not return to idle with outputs low");
   chk_min_instr: assert property ( // [R03]
      isLoad && chainOk_q |-> gap_q >= MIN_CYC)
      else $error("instruction shorter than the minimum");
   chk_delay_exact: assert property ( // [R02]
      isLoad && chainOk_q |-> gap_q == {1'b0, expDelay_q})
      else $error("instruction duration differs from its delay");
   chk_short_pulse: assert property ( // [R04]
      s_shortLoad |=> (patternOut == $past(patF)) ##1 (patternOut == 12'h000))
      else $error("one-cycle pulse not produced");
   chk_output_steady: assert property ( // [R16]
      $changed(patternOut) |-> $past(isLoad) || ($past(shortCnt_q) == 3'h1) || $past(resetAct))
      else $error("pattern changed inside an instruction");
   chk_stack_depth: assert property ( // [R09]
      (callSp_q <= 4'h8) && (loopSp_q <= 4'h8))
      else $error("stack pointer beyond eight levels");
   chk_call_push: assert property ( // [R09]
      isLoad && (opF == pps_seq_pkg::OP_CALL) && (callSp_q < 4'h8) && !resetAct
      |=> (callSp_q == $past(callSp_q) + 4'h1) && (pc_q == $past(dataF[11:0])))
      else $error("call did not push and jump");
   chk_status_run: assert property ( // [R13]
      (state_q == pps_seq_pkg::ST_EXEC) |=> statusLines[0] && hostStatus[0])
      else $error("running status missing");

endmodule
`default_nettype wire

// >>> pps_host_model.sv
`include "pps_seq_regs.svh"
`default_nettype none
// Host side: loads program words and gives start and reset through the host bus controller port.
module pps_host_model (
   input  wire logic                      core_clk,
   output logic                           progWrite,
   output logic [`SEQ_ADDR_BITS-1:0]      progAddr,
   output logic [`SEQ_WORD_BITS-1:0]      progWord,
   output logic                           hostStart,
   output logic                           hostReset
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle values at time zero.
   initial begin
      progWrite = 1'b0;
      progAddr  = '0;
      progWord  = '0;
      hostStart = 1'b0;
      hostReset = 1'b0;
   end

   // One word per strobe; address and word are inverted afterwards so that a stale value is never taken as valid.
   task automatic load_word(input logic [`SEQ_ADDR_BITS-1:0] a, input logic [`SEQ_WORD_BITS-1:0] w);
      @(posedge core_clk);
      #1;
      progWrite = 1'b1;
      progAddr  = a;
      progWord  = w;
      @(posedge core_clk);
      #1;
      progWrite = 1'b0;
      progAddr  = ~a;
      progWord  = ~w;
   endtask

   // One-cycle start or reset pulse; callers space starts far apart.
   task automatic pulse(input logic rst);
      @(posedge core_clk);
      #1;
      if (rst) begin
         hostReset = 1'b1;
      end else begin
         hostStart = 1'b1;
      end
      @(posedge core_clk);
      #1;
      hostStart = 1'b0;
      hostReset = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> pulse_pattern_sequencer_tb.sv
`include "pps_seq_regs.svh"
`default_nettype none
module pulse_pattern_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                         core_clk;
   logic                         rst_n;
   logic                         extTrigger;
   logic                         extReset;
   logic                         hostStart;
   logic                         hostReset;
   logic                         progWrite;
   logic [`SEQ_ADDR_BITS-1:0]    progAddr;
   logic [`SEQ_WORD_BITS-1:0]    progWord;
   logic [`SEQ_OUT_BITS-1:0]     patternOut;
   logic [`SEQ_STATUS_BITS-1:0]  statusLines;
   logic [`SEQ_STATUS_BITS-1:0]  hostStatus;
   logic [`SEQ_WORD_BITS-1:0]    mem [0:31];
   int                           mismatches = 0;
   int                           checked = 0;
   int                           i;

   pulse_pattern_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .extTrigger(extTrigger), .extReset(extReset),
      .hostStart(hostStart), .hostReset(hostReset), .progWrite(progWrite), .progAddr(progAddr),
      .progWord(progWord), .patternOut(patternOut), .statusLines(statusLines), .hostStatus(hostStatus));
   pps_host_model host (.core_clk(core_clk), .progWrite(progWrite), .progAddr(progAddr), .progWord(progWord),
      .hostStart(hostStart), .hostReset(hostReset));

   // Free-running core clock.
   initial begin
      core_clk = 1'b0;
      forever #(`SEQ_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   end

   task automatic finish_test();
      if (mismatches == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (e !== s) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
      end
   endtask

   // Expected pattern k cycles into an instruction of d cycles; a short pulse drops to zero after its length.
   function automatic logic [11:0] expPat(input logic [70:0] w, input int k, input longint d);
      int sh;
      sh = w[`SEQ_F_SHORT_LO +: `SEQ_SHORT_BITS];
      if (sh != 0 && sh < d - 1 && k >= sh) return 12'h000;
      return w[`SEQ_F_PAT_LO +: `SEQ_OUT_BITS];
   endfunction

   task automatic put(input int a, input logic [11:0] p, input logic [2:0] sh, input logic [3:0] op,
                      input logic [19:0] dat, input logic [31:0] dly);
      mem[a] = {p, sh, op, dat, dly};
      host.load_word(a[11:0], mem[a]);
   endtask

   task automatic checkIdle();
      chk("patternOut", 12'h000, patternOut);
      chk("idle", 1'b1, statusLines[`SEQ_ST_IDLE]);
   endtask

   // Starts the program and follows it cycle by cycle with a reference walk until stop, wait or a stack fault.
   task automatic runProg();
      int pc;
      int nx;
      int fin;
      int n;
      int ls[$];
      int cs[$];
      logic [70:0] w;
      logic [3:0] op;
      logic [19:0] dat;
      longint d;
      pc = 0;
      fin = -1;
      n = 0;
      host.pulse(1'b0);
      repeat (2) @(posedge core_clk);
      while (fin < 0 && n < 64) begin
         w = mem[pc];
         op = w[`SEQ_F_OP_LO +: 4];
         dat = w[`SEQ_F_DATA_LO +: `SEQ_DATA_BITS];
         d = (op == pps_seq_pkg::OP_LONG_DELAY) ? w[51:0] : w[31:0];
         if (d < `SEQ_MIN_INSTR_CYC) d = `SEQ_MIN_INSTR_CYC;
         for (int k = 0; k < d; k++) begin
            #2;
            chk("patternOut", expPat(w, k, d), patternOut);
            chk("hostStatus", statusLines, hostStatus);
            if (k == 1) chk("running", 1'b1, statusLines[`SEQ_ST_RUN]);
            @(posedge core_clk);
         end
         nx = pc + 1;
         case (op)
            pps_seq_pkg::OP_STOP: fin = `SEQ_ST_STOP;
            pps_seq_pkg::OP_WAIT: fin = `SEQ_ST_WAIT;
            pps_seq_pkg::OP_LOOP: if (ls.size() == 8) fin = `SEQ_ST_ERR; else ls.push_back(dat);
            pps_seq_pkg::OP_CALL: begin
               if (cs.size() == 8) fin = `SEQ_ST_ERR; else cs.push_back(nx);
               nx = dat[11:0];
            end
            pps_seq_pkg::OP_RETURN: if (cs.size() == 0) fin = `SEQ_ST_ERR; else nx = cs.pop_back();
            pps_seq_pkg::OP_BRANCH: nx = dat[11:0];
            pps_seq_pkg::OP_END_LOOP: begin
               if (ls.size() == 0) fin = `SEQ_ST_ERR;
               else if (ls[$] == 0) void'(ls.pop_back());
               else begin
                  ls[ls.size() - 1]--;
                  nx = dat[11:0];
               end
            end
            default: ;
         endcase
         pc = nx;
         n++;
      end
      repeat (2) @(posedge core_clk);
      #2;
      chk("end status", 1'b1, statusLines[fin]);
      chk("held pattern", expPat(w, 999, d), patternOut);
   endtask

   // Reset, then random and hand-made programs covering timing, flow control, faults, trigger and reset.
   initial begin
      extTrigger = 1'b0;
      extReset = 1'b0;
      rst_n = 1'b0;
      void'($urandom(1));
      repeat (5) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      @(posedge core_clk);
      #2;
      checkIdle();
      for (i = 0; i < 5; i++) begin
         put(i, 12'($urandom), ($urandom % 2) ? 3'($urandom % 4) : 3'h0, 4'h0, 20'h0,
             (i == 1) ? 32'h1 : 32'(6 + $urandom % 10));
      end
      put(5, 12'($urandom), 3'h0, pps_seq_pkg::OP_LONG_DELAY, 20'h0, 32'h9);
      put(6, 12'($urandom), 3'h0, pps_seq_pkg::OP_LOOP, 20'h2, 32'h6);
      put(7, 12'($urandom), 3'h1, 4'h0, 20'h0, 32'h7);
      put(8, 12'($urandom), 3'h0, pps_seq_pkg::OP_END_LOOP, 20'h7, 32'h6);
      put(9, 12'($urandom), 3'h0, pps_seq_pkg::OP_CALL, 20'h14, 32'h8);
      put(10, 12'($urandom), 3'h0, pps_seq_pkg::OP_BRANCH, 20'hC, 32'h6);
      put(11, 12'hFFF, 3'h0, 4'h0, 20'h0, 32'h6);
      put(12, 12'($urandom), 3'h0, pps_seq_pkg::OP_STOP, 20'h0, 32'h6);
      put(20, 12'($urandom), 3'h2, 4'h0, 20'h0, 32'hA);
      put(21, 12'($urandom), 3'h0, pps_seq_pkg::OP_RETURN, 20'h0, 32'h6);
      runProg();
      runProg();
      put(0, 12'hA5A, 3'h0, pps_seq_pkg::OP_RETURN, 20'h0, 32'h6);
      runProg();
      host.pulse(1'b1);
      // Status is registered, so the idle bit follows the state one edge after the reset pulse.
      @(posedge core_clk);
      #2;
      checkIdle();
      put(0, 12'h3C3, 3'h0, pps_seq_pkg::OP_WAIT, 20'h0, 32'h7);
      put(1, 12'h0F0, 3'h0, pps_seq_pkg::OP_STOP, 20'h0, 32'h6);
      runProg();
      @(posedge core_clk);
      #1;
      extTrigger = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      extTrigger = 1'b0;
      for (i = 0; i < 30 && patternOut !== 12'h0F0; i++) begin
         @(posedge core_clk);
         #2;
      end
      checked++;
      if (patternOut !== 12'h0F0) begin
         mismatches++;
         $display("CHECK FAILED resume expected f0 seen %0h", patternOut);
         finish_test();
      end
      put(0, 12'hFFF, 3'h0, pps_seq_pkg::OP_BRANCH, 20'h0, 32'h8);
      // A start given while the last instruction still runs is ignored, so let it reach the stop first.
      repeat (6) @(posedge core_clk);
      #2;
      chk("stopped", 1'b1, statusLines[`SEQ_ST_STOP]);
      host.pulse(1'b0);
      repeat (10) @(posedge core_clk);
      #1;
      extReset = 1'b1;
      #1;
      chk("branch loop", 12'hFFF, patternOut);
      repeat (4) @(posedge core_clk);
      #1;
      extReset = 1'b0;
      #1;
      checkIdle();
      finish_test();
   end
endmodule
`default_nettype wire
